// >>> hdl/hpop_pkg.sv
// hpop_pkg: shared constants and types of the hires/panel output port.
// assumes: one pixel clock domain at the link and one reference domain.
package hpop_pkg;

  // ****************************************************************
  // port select codes
  // ****************************************************************
  localparam logic [1:0] HPOP_SEL_RED   = 2'h0;
  localparam logic [1:0] HPOP_SEL_GREEN = 2'h1;
  localparam logic [1:0] HPOP_SEL_BLUE  = 2'h2;
  localparam logic [1:0] HPOP_SEL_EXT   = 2'h3;

  // ****************************************************************
  // bits per pixel codes (log2 of the depth)
  // ****************************************************************
  localparam logic [2:0] HPOP_BPP_1 = 3'h0;
  localparam logic [2:0] HPOP_BPP_2 = 3'h1;
  localparam logic [2:0] HPOP_BPP_4 = 3'h2;

  // ****************************************************************
  // counts and reset values
  // ****************************************************************
  localparam logic [1:0] HPOP_LAST_PHASE = 2'h3;
  localparam logic [7:0] HPOP_DATA_RST   = 8'h00;
  localparam logic [3:0] HPOP_NIB_RST    = 4'h0;
  localparam logic [1:0] HPOP_CNT_RST    = 2'h0;

  // ****************************************************************
  // mode status codes, seen from the reference domain
  // ****************************************************************
  localparam logic [1:0] HPOP_STAT_RAW   = 2'h0;
  localparam logic [1:0] HPOP_STAT_PANEL = 2'h1;
  localparam logic [1:0] HPOP_STAT_HIRES = 2'h2;

  typedef struct packed {
    logic       hires;
    logic [1:0] sel;
    logic       panel;
    logic       dual;
    logic       clk_gate;
    logic [2:0] bpp;
  } hpop_cfg_t;

  localparam hpop_cfg_t HPOP_CFG_RST = '0;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] cursor;
    logic [3:0] ext_lut;
    logic [3:0] ext_reg;
  } hpop_pix_t;

endpackage

// >>> hdl/hpop_grey_mod.sv
// hpop_grey_mod: turns one 4-bit shade into one modulated bit.
// assumes: raster and position counters come from the caller's domain.
`timescale 1ns/1ps
`default_nettype none
module hpop_grey_mod
  import hpop_pkg::*;
(
  input  wire logic [3:0] value_in,
  input  wire logic [1:0] raster_in,
  input  wire logic [1:0] hpos_in,
  output logic            bit_out
);

  // ****************************************************************
  // ordered threshold matrix
  // ****************************************************************
  // spreads the sixteen phases over a 4x4 tile so flicker stays low
  function automatic logic [3:0] hpop_thresh(input logic [3:0] idx);
    logic [3:0] t;
    t = 4'h0;
    case (idx)
      4'h0: t = 4'h0;  4'h1: t = 4'h8;  4'h2: t = 4'h2;  4'h3: t = 4'ha;
      4'h4: t = 4'hc;  4'h5: t = 4'h4;  4'h6: t = 4'he;  4'h7: t = 4'h6;
      4'h8: t = 4'h3;  4'h9: t = 4'hb;  4'ha: t = 4'h1;  4'hb: t = 4'h9;
      4'hc: t = 4'hf;  4'hd: t = 4'h7;  4'he: t = 4'hd;  4'hf: t = 4'h5;
      default: t = 4'h0;
    endcase
    return t;
  endfunction

  // high on value of the sixteen tile phases: average equals the shade
  assign bit_out = (value_in > hpop_thresh({raster_in, hpos_in})); // RULE_15

endmodule
`default_nettype wire

// >>> hdl/hpop_port.sv
// hpop_port: external 8-bit data port formatter, hires and panel modes.
// assumes: pixel data, display and fetch strobes arrive on PIX_CLK_IN;
// configuration levels arrive on REF_CLK_IN and change only rarely.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE_01) hires with select 10 gives byte per pixel
// (RULE_02) hires drives pixel clock with the data
// (RULE_03) hires byte comes from blue table
// (RULE_04) software loads blue table one-to-one
// (RULE_05) cursor palette bypassed, blue border allowed
// (RULE_06) eight cursor bits form four pairs
// (RULE_07) pair low bit set forces high bit
// (RULE_08) each pair steers matching output bits
// (RULE_09) panel enable with select 01 gives grey-scale
// (RULE_10) dual panel enable selects duplex
// (RULE_11) software turns converters off in panel mode
// (RULE_12) grey-scale only at 1, 2, 4 bpp
// (RULE_13) upper from green low nibble, lower from ext
// (RULE_14) single panel holds bits 3:0 low
// (RULE_15) shade modulated by raster and position
// (RULE_16) four bits per nibble, first on bit 7
// (RULE_17) duplex streams modulated and output together
// (RULE_18) software programs vertical timing as one panel
// (RULE_19) duplex fetches quad-word pairs, upper first
// (RULE_20) no panel bits gives raw multiplexer bytes
// (RULE_21) gated panel clock quarter rate during display
// (RULE_22) hires byte delayed one extra pixel
// (RULE_23) reset clears nibbles, modulation, data low
module hpop_port
  import hpop_pkg::*;
(
  input  wire logic       REF_CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic       PIX_CLK_IN,
  input  wire logic       HIRES_ENABLE_IN,
  input  wire logic [1:0] EXT_PORT_SELECT_IN,
  input  wire logic       PANEL_GREYSCALE_ENABLE_IN,
  input  wire logic       DUAL_PANEL_ENABLE_IN,
  input  wire logic       PORT_CLOCK_GATE_IN,
  input  wire logic [2:0] BPP_MODE_IN,
  input  wire logic [7:0] RED_LUT_IN,
  input  wire logic [7:0] GREEN_LUT_IN,
  input  wire logic [7:0] BLUE_LUT_OUT_IN,
  input  wire logic [7:0] CURSOR_MICRO_BITS_IN,
  input  wire logic [3:0] EXT_LUT_IN,
  input  wire logic [3:0] EXT_REG_HI_IN,
  input  wire logic       DISPLAY_ACTIVE_IN,
  input  wire logic       LINE_START_IN,
  input  wire logic       FRAME_START_IN,
  input  wire logic       FETCH_NEED_IN,
  input  wire logic       QWORD_ACK_IN,
  output logic [7:0]      EXT_DATA_OUT,
  output logic            EXT_PORT_CLOCK_OUT,
  output logic            QWORD_REQ_OUT,
  output logic            QWORD_UPPER_OUT,
  output logic [1:0]      MODE_STATUS_OUT
);

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef struct packed {
    hpop_cfg_t  cfg;
    logic [1:0] stat_s1;
    logic [1:0] stat_s2;
  } hpop_ref_st_t;

  typedef struct packed {
    hpop_cfg_t  cfg_s1;
    hpop_cfg_t  cfg_s2;
    logic [7:0] hires_q;
    logic [7:0] data;
    logic [3:0] nib_up;
    logic [3:0] nib_lo;
    logic [1:0] phase;
    logic [1:0] raster;
    logic [1:0] hpos;
    logic       ext_port_clock;
    logic       req;
    logic       upper;
    logic [1:0] mode;
  } hpop_pix_st_t;

  hpop_ref_st_t ref_st;
  hpop_ref_st_t next_ref_st;
  hpop_pix_st_t pix_st;
  hpop_pix_st_t next_pix_st;
  hpop_pix_t    pix;
  hpop_cfg_t    cfg;
  logic [7:0]   merge_val;
  logic         bit_up;
  logic         bit_lo;
  logic         hires_on;
  logic         lcd_on;
  logic         grey_ok;

  // ****************************************************************
  // cursor overlay
  // ****************************************************************
  function automatic logic [7:0] hpop_merge(input logic [7:0] video,
                                            input logic [7:0] cur);
    logic [7:0] r;
    r = video; // RULE_05
    for (int i = 0; i < 4; i++) begin // RULE_06
      if (cur[2*i]) begin
        r[2*i+:2] = {2{cur[2*i+1]}}; // RULE_07 RULE_08
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // reference domain: register config, catch status back
  // ****************************************************************
  always_comb begin
    next_ref_st             = ref_st;
    next_ref_st.cfg.hires   = HIRES_ENABLE_IN;
    next_ref_st.cfg.sel     = EXT_PORT_SELECT_IN;
    next_ref_st.cfg.panel   = PANEL_GREYSCALE_ENABLE_IN;
    next_ref_st.cfg.dual    = DUAL_PANEL_ENABLE_IN;
    next_ref_st.cfg.clk_gate = PORT_CLOCK_GATE_IN;
    next_ref_st.cfg.bpp     = BPP_MODE_IN;
    next_ref_st.stat_s1     = pix_st.mode;
    next_ref_st.stat_s2     = ref_st.stat_s1;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ref_st <= '{cfg: HPOP_CFG_RST, stat_s1: HPOP_STAT_RAW,
                  stat_s2: HPOP_STAT_RAW};
    end else begin
      ref_st <= next_ref_st;
    end
  end

  assign MODE_STATUS_OUT = ref_st.stat_s2;

  // ****************************************************************
  // pixel domain decode
  // ****************************************************************
  assign pix = '{red: RED_LUT_IN, green: GREEN_LUT_IN,
                 blue: BLUE_LUT_OUT_IN, cursor: CURSOR_MICRO_BITS_IN,
                 ext_lut: EXT_LUT_IN, ext_reg: EXT_REG_HI_IN};
  assign cfg       = pix_st.cfg_s2;
  assign merge_val = hpop_merge(pix.blue, pix.cursor); // RULE_03
  assign hires_on  = cfg.hires && (cfg.sel == HPOP_SEL_BLUE); // RULE_01
  // depths above 4 bpp fall back to the raw green byte
  assign grey_ok   = (cfg.bpp == HPOP_BPP_1) || (cfg.bpp == HPOP_BPP_2) ||
                     (cfg.bpp == HPOP_BPP_4); // RULE_12
  assign lcd_on    = cfg.panel && (cfg.sel == HPOP_SEL_GREEN) &&
                     grey_ok; // RULE_09

  hpop_grey_mod u_mod_up (
    .value_in  (pix.green[3:0]), // RULE_13
    .raster_in (pix_st.raster),
    .hpos_in   (pix_st.hpos),
    .bit_out   (bit_up)
  );

  hpop_grey_mod u_mod_lo (
    .value_in  (pix.ext_lut), // RULE_13 RULE_17
    .raster_in (pix_st.raster),
    .hpos_in   (pix_st.hpos),
    .bit_out   (bit_lo)
  );

  // ****************************************************************
  // pixel domain state
  // ****************************************************************
  always_comb begin
    next_pix_st         = pix_st;
    next_pix_st.cfg_s1  = ref_st.cfg;
    next_pix_st.cfg_s2  = pix_st.cfg_s1;
    next_pix_st.hires_q = merge_val;
    next_pix_st.ext_port_clock    = 1'b0;
    next_pix_st.mode    = hires_on ? HPOP_STAT_HIRES :
                          (lcd_on ? HPOP_STAT_PANEL : HPOP_STAT_RAW);
    if (FRAME_START_IN) begin
      next_pix_st.raster = HPOP_CNT_RST;
    end else if (LINE_START_IN) begin
      next_pix_st.raster = pix_st.raster + 2'h1;
    end
    if (LINE_START_IN) begin
      next_pix_st.hpos  = HPOP_CNT_RST;
      next_pix_st.phase = HPOP_CNT_RST;
    end else if (lcd_on && DISPLAY_ACTIVE_IN) begin
      next_pix_st.hpos  = pix_st.hpos + 2'h1;
      next_pix_st.phase = pix_st.phase + 2'h1;
    end
    if (hires_on) begin
      // extra retiming stage keeps the byte aligned with the clock
      next_pix_st.data = pix_st.hires_q; // RULE_22
      // one edge per byte; the receiver latches on both edges
      next_pix_st.ext_port_clock = ~pix_st.ext_port_clock; // RULE_02
    end else if (lcd_on) begin
      if (!cfg.dual) begin
        next_pix_st.data[3:0] = HPOP_NIB_RST; // RULE_14
      end
      if (DISPLAY_ACTIVE_IN) begin
        next_pix_st.nib_up[2'h3 - pix_st.phase] = bit_up; // RULE_16
        next_pix_st.nib_lo[2'h3 - pix_st.phase] = bit_lo; // RULE_17
        next_pix_st.ext_port_clock = cfg.clk_gate && pix_st.phase[1]; // RULE_21
        if (pix_st.phase == HPOP_LAST_PHASE) begin
          next_pix_st.data[7:4] = {pix_st.nib_up[3:1], bit_up};
          next_pix_st.data[3:0] = cfg.dual ?
                                  {pix_st.nib_lo[3:1], bit_lo} :
                                  HPOP_NIB_RST; // RULE_10 RULE_14
        end
      end
    end else begin
      // raw byte of the multiplexer, one pixel per clock
      case (cfg.sel) // RULE_20
        HPOP_SEL_RED:   next_pix_st.data = pix.red;
        HPOP_SEL_GREEN: next_pix_st.data = pix.green;
        HPOP_SEL_BLUE:  next_pix_st.data = pix.blue;
        default:        next_pix_st.data = {pix.ext_reg, pix.ext_lut};
      endcase
      next_pix_st.ext_port_clock = cfg.clk_gate && ~pix_st.ext_port_clock;
    end
    // quad-word fetches: duplex pairs them, upper half first
    if (FETCH_NEED_IN && !pix_st.req) begin
      next_pix_st.req   = 1'b1;
      next_pix_st.upper = 1'b1;
    end else if (pix_st.req && QWORD_ACK_IN) begin
      if (lcd_on && cfg.dual && pix_st.upper) begin
        next_pix_st.upper = 1'b0; // RULE_19
      end else begin
        next_pix_st.req   = 1'b0;
        next_pix_st.upper = 1'b1;
      end
    end
  end

  always_ff @(posedge PIX_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pix_st <= '{cfg_s1: HPOP_CFG_RST, cfg_s2: HPOP_CFG_RST,
                  hires_q: HPOP_DATA_RST, data: HPOP_DATA_RST,
                  nib_up: HPOP_NIB_RST, nib_lo: HPOP_NIB_RST,
                  phase: HPOP_CNT_RST, raster: HPOP_CNT_RST,
                  hpos: HPOP_CNT_RST, ext_port_clock: 1'b0, req: 1'b0,
                  upper: 1'b1, mode: HPOP_STAT_RAW}; // RULE_23
    end else begin
      pix_st <= next_pix_st;
    end
  end

  assign EXT_DATA_OUT       = pix_st.data;
  assign EXT_PORT_CLOCK_OUT = pix_st.ext_port_clock;
  assign QWORD_REQ_OUT      = pix_st.req;
  assign QWORD_UPPER_OUT    = pix_st.upper;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_hires_path;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      hires_on [*3] |-> EXT_DATA_OUT == $past(merge_val, 2);
  endproperty
  a_hires_path: assert property (p_hires_path) // RULE_22
    else $error("hires byte not two pixels behind the overlay");

  property p_cursor_force;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      hires_on [*3] ##0 $past(CURSOR_MICRO_BITS_IN[0], 2)
        |-> EXT_DATA_OUT[1:0] == {2{$past(CURSOR_MICRO_BITS_IN[1], 2)}};
  endproperty
  a_cursor_force: assert property (p_cursor_force) // RULE_07
    else $error("cursor pair did not force output bits");

  property p_hires_clock;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      hires_on ##1 hires_on |-> EXT_PORT_CLOCK_OUT != $past(EXT_PORT_CLOCK_OUT);
  endproperty
  a_hires_clock: assert property (p_hires_clock) // RULE_02
    else $error("hires port clock did not toggle");

  property p_single_low;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      (lcd_on && !cfg.dual) [*6] |-> EXT_DATA_OUT[3:0] == 4'h0;
  endproperty
  a_single_low: assert property (p_single_low) // RULE_14
    else $error("single panel low nibble not held low");

  property p_raw_red;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      (!hires_on && !lcd_on && cfg.sel == HPOP_SEL_RED) ##1
      (!hires_on && !lcd_on && cfg.sel == HPOP_SEL_RED)
        |-> EXT_DATA_OUT == $past(RED_LUT_IN);
  endproperty
  a_raw_red: assert property (p_raw_red) // RULE_20
    else $error("raw red byte not passed");

  property p_gate_off;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      (lcd_on && !cfg.clk_gate) |=> !EXT_PORT_CLOCK_OUT;
  endproperty
  a_gate_off: assert property (p_gate_off) // RULE_21
    else $error("panel clock ran with the gate off");

  property p_quarter_rate;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      // single panel clears the stale low nibble on the first panel edge
      lcd_on [*2] ##1 (lcd_on && $changed(EXT_DATA_OUT))
        |-> $past(pix_st.phase) == HPOP_LAST_PHASE;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate) // RULE_16
    else $error("panel nibble changed off the fourth pixel");

  property p_pair_order;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      (lcd_on && cfg.dual && QWORD_REQ_OUT && QWORD_UPPER_OUT &&
       QWORD_ACK_IN) |=> (QWORD_REQ_OUT && !QWORD_UPPER_OUT);
  endproperty
  a_pair_order: assert property (p_pair_order) // RULE_19
    else $error("duplex fetch did not await the lower quad-word");

  property p_phase_step;
    @(posedge PIX_CLK_IN) disable iff (!RESET_N_IN)
      (lcd_on && DISPLAY_ACTIVE_IN && !LINE_START_IN)
        |=> pix_st.phase == 2'($past(pix_st.phase) + 2'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) // RULE_15
    else $error("modulation phase did not advance");

endmodule
`default_nettype wire

// >>> bench/hpop_mem_model.sv
// hpop_mem_model: memory controller stand-in answering quad-word requests.
// assumes: request and upper flag are registered on the pixel clock.
`timescale 1ns/1ps
`default_nettype none
module hpop_mem_model
  import hpop_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       req_in,
  input  wire logic       upper_in,
  input  wire logic       slow_in,
  output logic            ack_out,
  output int              n_ack_out,
  output logic [1:0]      log_out
);
  int wait_cnt;

  // ****
  // answer on the falling edge, one pulse per quad-word
  // ****
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      wait_cnt <= 0;
      n_ack_out <= 0;
      log_out <= 2'h0;
    end else begin
      ack_out <= 1'b0;
      // gap after each ack lets the upper flag move on first
      if (req_in && !ack_out) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow_in ? 5 : 1)) begin
          ack_out <= 1'b1;
          wait_cnt <= 0;
          n_ack_out <= n_ack_out + 1;
          log_out <= {log_out[0], upper_in};
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/hpop_port_tb.sv
// hpop_port_tb: self-checking bench of the hires/panel output port.
// assumes: hpop_pkg and the memory controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hpop_port_tb
  import hpop_pkg::*;
;
  logic       ref_clk = 1'b0, pix_clk = 1'b0, rst_n = 1'b0;
  logic       hires = 1'b0, pnl = 1'b0, dual = 1'b0, gate = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [2:0] bpp = 3'h0;
  logic [7:0] red = 8'h00, grn = 8'h00, blu = 8'h00, cur = 8'h00;
  logic [3:0] elut = 4'h0, ereg = 4'h0;
  logic       act = 1'b0, lst = 1'b0, fst = 1'b0, need = 1'b0;
  logic       slow = 1'b0;
  wire logic [7:0] ed;
  wire logic [1:0] stat, ack_log;
  wire logic       ext_port_clock, req, upper, ack;
  int              n_ack;
  int              error_cnt = 0, n_checks = 0, cyc = 0;

  always #4 ref_clk = ~ref_clk;
  // one-off offset keeps the pixel edges clear of the reference edges
  always begin
    if (cyc == 0) #1.7;
    #6 pix_clk = ~pix_clk;
  end

  hpop_port i_dut (.REF_CLK_IN(ref_clk), .RESET_N_IN(rst_n),
    .PIX_CLK_IN(pix_clk), .HIRES_ENABLE_IN(hires), .EXT_PORT_SELECT_IN(sel),
    .PANEL_GREYSCALE_ENABLE_IN(pnl), .DUAL_PANEL_ENABLE_IN(dual),
    .PORT_CLOCK_GATE_IN(gate), .BPP_MODE_IN(bpp), .RED_LUT_IN(red),
    .GREEN_LUT_IN(grn), .BLUE_LUT_OUT_IN(blu), .CURSOR_MICRO_BITS_IN(cur),
    .EXT_LUT_IN(elut), .EXT_REG_HI_IN(ereg), .DISPLAY_ACTIVE_IN(act),
    .LINE_START_IN(lst), .FRAME_START_IN(fst), .FETCH_NEED_IN(need),
    .QWORD_ACK_IN(ack), .EXT_DATA_OUT(ed), .EXT_PORT_CLOCK_OUT(ext_port_clock),
    .QWORD_REQ_OUT(req), .QWORD_UPPER_OUT(upper), .MODE_STATUS_OUT(stat));

  hpop_mem_model i_mem (.clk_in(pix_clk), .rst_n_in(rst_n), .req_in(req),
    .upper_in(upper), .slow_in(slow), .ack_out(ack), .n_ack_out(n_ack),
    .log_out(ack_log));

  // ****
  // shared tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop();
    end
  end

  // config only moves while the display is idle
  task automatic cfg(input logic h, input logic [1:0] s, input logic p,
                     input logic d, input logic g, input logic [2:0] b);
    @(negedge pix_clk) act = 1'b0;
    @(negedge ref_clk);
    {hires, sel, pnl, dual, gate, bpp} = {h, s, p, d, g, b};
    repeat (10) @(negedge pix_clk);
  endtask

  task automatic frame(input logic [15:0] up, input logic [15:0] lo,
                       output int ones[8], output int hi);
    logic [15:0] u, l;
    ones = '{default: 0};
    hi = 0;
    @(negedge pix_clk) fst = 1'b1;
    @(negedge pix_clk) fst = 1'b0;
    repeat (4) begin
      u = up;
      l = lo;
      for (int k = 0; k < 7; k++) begin
        @(negedge pix_clk);
        hi += ext_port_clock;
        if (k == 0) chk({7'h00, ext_port_clock}, 8'h00, "clock idle");
        if (k == 6) for (int b = 0; b < 8; b++) ones[b] += ed[b];
        lst = (k == 0);
        act = (k > 0 && k < 5);
        if (act) begin
          grn = {4'($urandom), u[15:12]};
          elut = l[15:12];
          u = u << 4;
          l = l << 4;
        end
      end
    end
  endtask

  // ****
  // tests
  // ****
  task automatic t_raw();
    logic [7:0] e;
    logic [1:0] s;
    for (int t = 0; t < 5; t++) begin
      s = (t == 4) ? HPOP_SEL_GREEN : 2'(t);
      cfg(1'b0, s, t == 4, 1'b0, 1'b1, 3'h3);
      act = 1'b1;
      {red, grn, blu, elut, ereg} = $urandom;
      repeat (4) @(negedge pix_clk);
      case (s)
        HPOP_SEL_RED:   e = red;
        HPOP_SEL_GREEN: e = grn;
        HPOP_SEL_BLUE:  e = blu;
        default:        e = {ereg, elut};
      endcase
      chk(ed, e, "raw byte");
      chk(8'(stat), 8'(HPOP_STAT_RAW), "raw status");
    end
    $display("test raw done");
  endtask

  task automatic t_hires();
    logic [7:0] q[$];
    logic [7:0] e;
    logic       pc;
    cfg(1'b1, HPOP_SEL_BLUE, 1'b0, 1'b0, 1'b1, HPOP_BPP_4);
    chk(8'(stat), 8'(HPOP_STAT_HIRES), "hires status");
    act = 1'b1;
    pc = ext_port_clock;
    repeat (200) begin
      @(negedge pix_clk);
      chk({7'h00, ext_port_clock}, {7'h00, ~pc}, "hires clock");
      pc = ext_port_clock;
      if (q.size() == 2) chk(ed, q.pop_front(), "hires byte");
      blu = 8'($urandom);
      cur = 8'($urandom);
      for (int i = 0; i < 8; i += 2) begin
        e[i +: 2] = cur[i] ? {2{cur[i + 1]}} : blu[i +: 2];
      end
      q.push_back(e);
    end
    $display("test hires done");
  endtask

  task automatic t_panel(input logic d);
    int         ones[8];
    int         hi, s, s2, up, lo, a0;
    logic       g;
    logic [2:0] b;
    b = 3'($urandom_range(2, 0));
    for (int t = 0; t < 8; t++) begin
      g = (t < 4 || t % 2 == 1);
      cfg(1'b0, HPOP_SEL_GREEN, 1'b1, d, g, b);
      chk(8'(stat), 8'(HPOP_STAT_PANEL), "panel status");
      s = $urandom_range(15, 0);
      s2 = $urandom_range(15, 0);
      if (t < 4) frame({4{4'(s)}}, {4{4'(s2)}}, ones, hi);
      else frame(16'hf000 >> (4 * (t - 4)), 16'h000f << (4 * (t - 4)), ones, hi);
      up = ones[7] + ones[6] + ones[5] + ones[4];
      lo = ones[3] + ones[2] + ones[1] + ones[0];
      if (t < 4) begin
        chk(8'(up), 8'(s), "upper shade");
        chk(8'(lo), d ? 8'(s2) : 8'h00, "lower shade");
      end else begin
        chk(8'(up == ones[11 - t] && up >= 3), 8'h01, "upper order");
        chk(8'(d ? (lo == ones[t - 4] && lo >= 3) : lo == 0), 8'h01, "lower order");
      end
      chk(8'(hi), g ? 8'h08 : 8'h00, "panel clock");
    end
    a0 = n_ack;
    slow = 1'($urandom);
    @(negedge pix_clk) need = 1'b1;
    @(negedge pix_clk) need = 1'b0;
    repeat (30) @(negedge pix_clk);
    chk(8'(n_ack - a0), d ? 8'h02 : 8'h01, "ack count");
    chk({6'h00, d ? ack_log : 2'h2}, 8'h02, "upper first");
    chk({7'h00, req}, 8'h00, "request done");
    $display("test panel dual=%0d done", d);
  endtask

  initial begin
    void'($urandom(32'hb981));
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(ed, HPOP_DATA_RST, "reset data");
    chk({3'h0, ext_port_clock, req, upper, stat}, 8'h04, "reset state");
    rst_n = 1'b1;
    repeat (4) @(negedge pix_clk);
    t_raw();
    t_hires();
    t_panel(1'b0);
    t_panel(1'b1);
    @(negedge ref_clk) rst_n = 1'b0;
    repeat (3) @(negedge pix_clk);
    chk(ed, HPOP_DATA_RST, "mid reset data");
    chk({3'h0, ext_port_clock, req, upper, stat}, 8'h04, "mid reset state");
    $display("test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
